// >>> scs_change_status.sv
// Spare-bit pattern change status, enable and interrupt registers
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
//
// Summary of operation
// - Bit 7 sets when the debounced nibble starts or stops being 1111.
// - Bit 6 sets when the debounced nibble starts or stops being 1110.
// - Bit 5 sets when the debounced nibble starts or stops being 1100.
// - Bit 4 sets when the debounced nibble starts or stops being 1010.
// - Bit 3 sets when the debounced nibble starts or stops being 1000.
// - Bit 2 sets when the nibble enters or leaves 001x, last bit ignored.
// - Reading the status register clears all its bits.
// - A bit reads 1 after a change since the last read or clearing write to it, else 0; resets 0.
// - Interrupt asserts for a latched change only when its enable is set.
// - Bit 1 sets on another combination; bit 0 on entering or leaving 0000.
// - Each flag has a read-write enable at the same position, reset 0.
//
module scs_change_status (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire scs_pkg::scs_nibble_type      sa6_nibble,
  input  wire logic [scs_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [scs_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [scs_pkg::DATA_W-1:0]        reg_rdata,
  output logic                              irq
);
  import scs_pkg::*;

  // Decoding shared by the read and write paths
  function automatic scs_sel_type decode(input logic [ADDR_W-1:0] addr);
    scs_sel_type sel;
    sel = SCS_SEL_NONE;
    case (addr)
      ADDR_STATUS: begin
        sel = SCS_SEL_STATUS;
      end
      ADDR_ENABLE: begin
        sel = SCS_SEL_ENABLE;
      end
      ADDR_CLEAR: begin
        sel = SCS_SEL_CLEAR;
      end
      ADDR_LEVEL: begin
        sel = SCS_SEL_LEVEL;
      end
      default: begin
        sel = SCS_SEL_NONE;
      end
    endcase
    return sel;
  endfunction

  scs_flags_type  spare_bit_change_status_reg;
  scs_flags_type  spare_bit_change_enable_reg;
  scs_flags_type  events;
  scs_flags_type  clear_mask;
  scs_flags_type  next_status;
  scs_nibble_type prev_nibble;
  logic           primed;
  scs_sel_type    rd_sel;
  scs_sel_type    wr_sel;
  logic           rd_status;
  logic           wr_enable;
  logic           wr_clear;
  logic [DATA_W-1:0] next_rdata;

  scs_pattern_detect u_detect (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .nibble      (sa6_nibble),
    .events      (events),
    .prev_nibble (prev_nibble),
    .primed      (primed)
  );

  always_comb begin
    rd_sel    = decode(reg_addr);
    wr_sel    = decode(reg_addr);
    rd_status = reg_rd && (rd_sel == SCS_SEL_STATUS);
    wr_enable = reg_wr && (wr_sel == SCS_SEL_ENABLE);
    wr_clear  = reg_wr && (wr_sel == SCS_SEL_CLEAR);
  end

  // A status read wipes every bit; the clear register wipes chosen bits
  always_comb begin
    clear_mask = FLAGS_NONE;
    if (rd_status) begin
      clear_mask = ~FLAGS_NONE;
    end else if (wr_clear) begin
      clear_mask = reg_wdata[FLAG_W-1:0];
    end
  end

  // Set is applied after clear so a same-cycle event survives
  always_comb begin
    next_status = (spare_bit_change_status_reg & ~clear_mask) | events;
  end

  // Flags for 1111, 1110, 1100, 1010, 1000, 001x, other and 0000
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      spare_bit_change_status_reg <= STATUS_RESET;
    end else begin
      spare_bit_change_status_reg <= next_status;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      spare_bit_change_enable_reg <= ENABLE_RESET;
    end else if (wr_enable) begin
      spare_bit_change_enable_reg <= reg_wdata[FLAG_W-1:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    next_rdata = READ_IDLE;
    if (reg_rd) begin
      case (rd_sel)
        SCS_SEL_STATUS: begin
          next_rdata = spare_bit_change_status_reg;
        end
        SCS_SEL_ENABLE: begin
          next_rdata = spare_bit_change_enable_reg;
        end
        SCS_SEL_LEVEL: begin
          next_rdata = READ_IDLE;
          next_rdata[LEVEL_NIB_LSB +: NIB_W] = prev_nibble;
          next_rdata[LEVEL_PRIMED_BIT] = primed;
        end
        default: begin
          // Write-only clear register and holes read as zero
          next_rdata = READ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= READ_IDLE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Level output; clears as soon as the flag or its enable goes
  always_comb begin
    irq = |(spare_bit_change_status_reg & spare_bit_change_enable_reg);
  end

  // Assertions

  sequence s_status_read;
    reg_rd && (reg_addr == ADDR_STATUS);
  endsequence

  sequence s_quiet_cycle;
    events == FLAGS_NONE;
  endsequence

  property p_all_ones;
    @(posedge clk) disable iff (sys_rst)
      (primed && ((sa6_nibble == PAT_ALL_ONES) != (prev_nibble == PAT_ALL_ONES)))
      |=> spare_bit_change_status_reg[BIT_ALL_ONES];
  endproperty
  a_all_ones: assert property (p_all_ones)
    else $error("all-ones change not latched");

  property p_pattern_e;
    @(posedge clk) disable iff (sys_rst)
      (primed && $changed(sa6_nibble == PAT_E) && $past(primed))
      |-> ##1 spare_bit_change_status_reg[BIT_PATTERN_E];
  endproperty
  a_pattern_e: assert property (p_pattern_e)
    else $error("1110 change not latched");

  property p_pattern_c;
    @(posedge clk) disable iff (sys_rst)
      (!primed || ((sa6_nibble == PAT_C) == (prev_nibble == PAT_C)))
      |-> !events[BIT_PATTERN_C];
  endproperty
  a_pattern_c: assert property (p_pattern_c)
    else $error("1100 flag raised without a change");

  property p_pattern_a;
    @(posedge clk) disable iff (sys_rst)
      (primed && (sa6_nibble == PAT_A) && (prev_nibble != PAT_A))
      |=> spare_bit_change_status_reg[BIT_PATTERN_A] ##1
          (spare_bit_change_status_reg[BIT_PATTERN_A] ||
           $past(reg_rd && (reg_addr == ADDR_STATUS)) ||
           $past(reg_wr && (reg_addr == ADDR_CLEAR)));
  endproperty
  a_pattern_a: assert property (p_pattern_a)
    else $error("1010 entry flag not held");

  property p_pattern_8;
    @(posedge clk) disable iff (sys_rst)
      (primed && (prev_nibble == PAT_8) && (sa6_nibble != PAT_8))
      |=> spare_bit_change_status_reg[BIT_PATTERN_8];
  endproperty
  a_pattern_8: assert property (p_pattern_8)
    else $error("1000 exit not latched");

  property p_pat_2or3;
    @(posedge clk) disable iff (sys_rst)
      (primed && (prev_nibble == 4'h2) && (sa6_nibble == 4'h3))
      |-> !events[BIT_PAT_2OR3];
  endproperty
  a_pat_2or3: assert property (p_pat_2or3)
    else $error("001x flag raised on the ignored bit");

  property p_read_clears;
    @(posedge clk) disable iff (sys_rst)
      (s_status_read and s_quiet_cycle) |=> (spare_bit_change_status_reg == FLAGS_NONE);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status not cleared by read");

  property p_read_value;
    @(posedge clk) disable iff (sys_rst)
      s_status_read |=> (reg_rdata == $past(spare_bit_change_status_reg)) ##1
                        (reg_rdata == READ_IDLE || $past(reg_rd));
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("status read data wrong");

  property p_irq_gate;
    @(posedge clk) disable iff (sys_rst)
      ((spare_bit_change_status_reg & spare_bit_change_enable_reg) == FLAGS_NONE)
      |-> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without an enabled flag");

  property p_other_zero;
    @(posedge clk) disable iff (sys_rst)
      (primed && (sa6_nibble != prev_nibble) &&
       ((sa6_nibble == 4'h5) || (sa6_nibble == PAT_ALL_ZERO) || (prev_nibble == PAT_ALL_ZERO)))
      |=> (spare_bit_change_status_reg[BIT_OTHER] ||
           spare_bit_change_status_reg[BIT_ALL_ZERO]);
  endproperty
  a_other_zero: assert property (p_other_zero)
    else $error("other or all-zero change not latched");

  property p_enable_write;
    @(posedge clk) disable iff (sys_rst)
      (reg_wr && (reg_addr == ADDR_ENABLE)) ##1 (reg_rd && (reg_addr == ADDR_ENABLE))
      |=> (reg_rdata == $past(reg_wdata, 2));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable register did not keep written value");

  property p_event_kept;
    @(posedge clk) disable iff (sys_rst)
      (s_status_read and (events != FLAGS_NONE))
      |=> ((spare_bit_change_status_reg & $past(events)) == $past(events));
  endproperty
  a_event_kept: assert property (p_event_kept)
    else $error("event lost during clearing read");

  property p_irq_raise;
    @(posedge clk) disable iff (sys_rst)
      ((spare_bit_change_status_reg & spare_bit_change_enable_reg) != FLAGS_NONE)
      |-> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("enabled flag without interrupt");

  property p_events_unprimed;
    @(posedge clk) disable iff (sys_rst)
      !primed
      |-> (events == FLAGS_NONE);
  endproperty
  a_events_unprimed: assert property (p_events_unprimed)
    else $error("event reported before first nibble sample");

  property p_set_needs_event;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |=> ((spare_bit_change_status_reg & ~$past(spare_bit_change_status_reg) &
                 ~$past(events)) == FLAGS_NONE);
  endproperty
  a_set_needs_event: assert property (p_set_needs_event)
    else $error("status bit rose without an event");

  // Bits only fall on a status read or a clear write
  property p_status_hold;
    @(posedge clk) disable iff (sys_rst)
      (!(reg_rd && (reg_addr == ADDR_STATUS)) && !(reg_wr && (reg_addr == ADDR_CLEAR)))
      |=> ((spare_bit_change_status_reg & $past(spare_bit_change_status_reg)) ==
           $past(spare_bit_change_status_reg));
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("status bit lost without a read");

  property p_enable_stable;
    @(posedge clk) disable iff (sys_rst)
      !(reg_wr && (reg_addr == ADDR_ENABLE))
      |=> $stable(spare_bit_change_enable_reg);
  endproperty
  a_enable_stable: assert property (p_enable_stable)
    else $error("enable register changed without a write");

  property p_pattern_c_latch;
    @(posedge clk) disable iff (sys_rst)
      (primed && ((sa6_nibble == PAT_C) != (prev_nibble == PAT_C)))
      |=> spare_bit_change_status_reg[BIT_PATTERN_C];
  endproperty
  a_pattern_c_latch: assert property (p_pattern_c_latch)
    else $error("1100 change not latched");

  property p_pat_2or3_latch;
    @(posedge clk) disable iff (sys_rst)
      (primed && (((sa6_nibble & PAT_2OR3_MASK) == PAT_2OR3) !=
                  ((prev_nibble & PAT_2OR3_MASK) == PAT_2OR3)))
      |=> spare_bit_change_status_reg[BIT_PAT_2OR3];
  endproperty
  a_pat_2or3_latch: assert property (p_pat_2or3_latch)
    else $error("001x entry or exit not latched");

  property p_pattern_a_exit;
    @(posedge clk) disable iff (sys_rst)
      (primed && (prev_nibble == PAT_A) && (sa6_nibble != PAT_A))
      |=> spare_bit_change_status_reg[BIT_PATTERN_A];
  endproperty
  a_pattern_a_exit: assert property (p_pattern_a_exit)
    else $error("1010 exit not latched");

  property p_pattern_8_entry;
    @(posedge clk) disable iff (sys_rst)
      (primed && (sa6_nibble == PAT_8) && (prev_nibble != PAT_8))
      |=> spare_bit_change_status_reg[BIT_PATTERN_8];
  endproperty
  a_pattern_8_entry: assert property (p_pattern_8_entry)
    else $error("1000 entry not latched");

  property p_all_zero_latch;
    @(posedge clk) disable iff (sys_rst)
      (primed && ((sa6_nibble == PAT_ALL_ZERO) != (prev_nibble == PAT_ALL_ZERO)))
      |=> spare_bit_change_status_reg[BIT_ALL_ZERO];
  endproperty
  a_all_zero_latch: assert property (p_all_zero_latch)
    else $error("0000 change not latched");

endmodule

// >>> scs_pkg.sv
// Constants, register map and types for the spare-bit change status block
package scs_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 8;
  localparam int NIB_W  = 4;

  localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'h0B0C;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 16'h0B0D;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR  = 16'h0B0E;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL  = 16'h0B0F;

  localparam int BIT_ALL_ONES  = 7;
  localparam int BIT_PATTERN_E = 6;
  localparam int BIT_PATTERN_C = 5;
  localparam int BIT_PATTERN_A = 4;
  localparam int BIT_PATTERN_8 = 3;
  localparam int BIT_PAT_2OR3  = 2;
  localparam int BIT_OTHER     = 1;
  localparam int BIT_ALL_ZERO  = 0;

  localparam logic [NIB_W-1:0] PAT_ALL_ONES  = 4'hF;
  localparam logic [NIB_W-1:0] PAT_E         = 4'hE;
  localparam logic [NIB_W-1:0] PAT_C         = 4'hC;
  localparam logic [NIB_W-1:0] PAT_A         = 4'hA;
  localparam logic [NIB_W-1:0] PAT_8         = 4'h8;
  localparam logic [NIB_W-1:0] PAT_2OR3      = 4'h2;
  localparam logic [NIB_W-1:0] PAT_2OR3_MASK = 4'hE;
  localparam logic [NIB_W-1:0] PAT_ALL_ZERO  = 4'h0;
  localparam logic [NIB_W-1:0] NIBBLE_RESET  = 4'h0;

  localparam logic [FLAG_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_NONE   = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE    = 8'h00;

  // Level register layout
  localparam int LEVEL_NIB_LSB    = 0;
  localparam int LEVEL_PRIMED_BIT = 4;

  typedef logic [FLAG_W-1:0] scs_flags_type;
  typedef logic [NIB_W-1:0]  scs_nibble_type;

  typedef enum {
    SCS_SEL_NONE,
    SCS_SEL_STATUS,
    SCS_SEL_ENABLE,
    SCS_SEL_CLEAR,
    SCS_SEL_LEVEL
  } scs_sel_type;

endpackage

// >>> scs_pattern_detect.sv
// Classifies the debounced spare nibble and flags pattern entry and exit
`timescale 1ns/1ps
module scs_pattern_detect (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire scs_pkg::scs_nibble_type nibble,
  output scs_pkg::scs_flags_type  events,
  output scs_pkg::scs_nibble_type prev_nibble,
  output logic                    primed
);
  import scs_pkg::*;

  function automatic scs_flags_type classify(input scs_nibble_type nib);
    scs_flags_type m;
    m = FLAGS_NONE;
    m[BIT_ALL_ONES]  = (nib == PAT_ALL_ONES);
    m[BIT_PATTERN_E] = (nib == PAT_E);
    m[BIT_PATTERN_C] = (nib == PAT_C);
    m[BIT_PATTERN_A] = (nib == PAT_A);
    m[BIT_PATTERN_8] = (nib == PAT_8);
    m[BIT_PAT_2OR3]  = ((nib & PAT_2OR3_MASK) == PAT_2OR3);
    m[BIT_ALL_ZERO]  = (nib == PAT_ALL_ZERO);
    m[BIT_OTHER]     = (m == FLAGS_NONE);
    return m;
  endfunction

  scs_flags_type match_now;
  scs_flags_type match_before;
  scs_flags_type change;

  always_comb begin
    match_now    = classify(nibble);
    match_before = classify(prev_nibble);
    change       = match_now ^ match_before;
  end

  // History of the nibble; no event until one sample is held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_nibble <= NIBBLE_RESET;
    end else begin
      prev_nibble <= nibble;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
    end
  end

  always_comb begin
    events = FLAGS_NONE;
    if (primed) begin
      events = change;
      // Any move onto an unnamed value counts, even between two of them
      events[BIT_OTHER] = match_now[BIT_OTHER] && (nibble != prev_nibble);
    end
  end

endmodule

// >>> tb.sv
// Self-checking bench for the spare-bit change status block
`timescale 1ns/1ps
module tb;
  import scs_pkg::*;

  logic                clk;
  logic                sys_rst;
  scs_nibble_type      sa6_nibble;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [DATA_W-1:0]   reg_rdata;
  logic                irq;
  int                  failures;
  int                  checks_done;
  scs_nibble_type      prev_nib;
  scs_flags_type       en;
  logic [DATA_W-1:0]   d;
  scs_nibble_type      seq [11] = '{4'hF, 4'hE, 4'hC, 4'hA, 4'h8, 4'h2, 4'h3, 4'h5, 4'h7,
                                    4'h0, 4'h0};

  scs_change_status dut (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .sa6_nibble(sa6_nibble),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .irq       (irq)
  );

  always #25 clk = ~clk;

  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Match vector of a nibble; bit 1 is worked out separately
  function automatic scs_flags_type pm(input scs_nibble_type v);
    pm = {v == 4'hF, v == 4'hE, v == 4'hC, v == 4'hA, v == 4'h8, v[3:1] == 3'b001, 1'b0,
          v == 4'h0};
  endfunction

  function automatic scs_flags_type expect_flags(input scs_nibble_type a, input scs_nibble_type b);
    expect_flags = pm(a) ^ pm(b);
    expect_flags[1] = (pm(b) == 8'h00) && (a != b);
  endfunction

  task automatic step(input scs_nibble_type v);
    scs_flags_type e;
    e = expect_flags(prev_nib, v);
    @(posedge clk);
    sa6_nibble <= v;
    @(posedge clk);
    #1 chk({7'h00, irq}, {7'h00, |(e & en)});
    rd(ADDR_STATUS, d);
    chk(d, e);
    chk({7'h00, irq}, 8'h00);
    prev_nib = v;
  endtask

  initial begin
    clk         = 1'b0;
    sys_rst     = 1'b1;
    sa6_nibble  = 4'h0;
    reg_addr    = 16'h0000;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    failures    = 0;
    checks_done = 0;
    prev_nib    = 4'h0;
    en          = 8'h00;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_STATUS, d);
    chk(d, 8'h00);
    rd(ADDR_ENABLE, d);
    chk(d, 8'h00);
    wr(ADDR_ENABLE, 8'hA5);
    rd(ADDR_ENABLE, d);
    chk(d, 8'hA5);
    // Unmapped place ignores writes; it and the write-only clear register read zero
    wr(16'h0B10, 8'hFF);
    rd(16'h0B10, d);
    chk(d, 8'h00);
    rd(ADDR_CLEAR, d);
    chk(d, 8'h00);
    rd(ADDR_ENABLE, d);
    chk(d, 8'hA5);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ADDR_ENABLE;
    reg_wdata <= 8'h3C;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, 8'h3C);
    // Mixed enables so irq must follow only the enabled flags
    en = 8'h85;
    wr(ADDR_ENABLE, en);
    foreach (seq[i]) step(seq[i]);
    // Change arriving in the very cycle the clearing read is taken
    @(posedge clk);
    reg_rd     <= 1'b1;
    reg_addr   <= ADDR_STATUS;
    sa6_nibble <= 4'hF;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, 8'h00);
    rd(ADDR_STATUS, d);
    chk(d, 8'h81);
    @(posedge clk);
    #1 chk(reg_rdata, 8'h00);
    rd(ADDR_LEVEL, d);
    chk(d, 8'h1F);
    // Clear path removes only the bits written as one
    @(posedge clk);
    sa6_nibble <= 4'h0;
    wr(ADDR_CLEAR, 8'h80);
    rd(ADDR_STATUS, d);
    chk(d, 8'h01);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, d);
    chk(d, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // Second reset in mid-run brings the enables back to zero
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_ENABLE, d);
    chk(d, 8'h00);
    rd(ADDR_STATUS, d);
    chk(d, 8'h00);
    tally_and_finish();
  end

  // Whole run needs under a hundred cycles; this allows ample margin
  initial begin
    #(50 * 4000);
    failures++;
    tally_and_finish();
  end
endmodule
